// ==== rtl/panel_map.vh ====
`ifndef PANEL_MAP_VH
`define PANEL_MAP_VH
// register byte offsets
`define REG_CTRL        4'h0
`define REG_SWITCH      4'h4
`define REG_CAUSE       4'h8
`define REG_STATUS      4'hC
// control register fields
`define CTRL_RESET_BIT  0
`define CTRL_OVRD_BIT   1
`define CTRL_PURGE_BIT  2
`define CTRL_CABP_BIT   3
`define CTRL_MANUAL_BIT 4
`define CTRL_HIGH_BIT   5
`define CTRL_FEED_BIT   6
`define CTRL_RESET_VAL  8'h00
// module switch field: two bits per module, 2'h0 off, 2'h1 on, 2'h2 standby
`define SW_OFF          2'h0
`define SW_ON           2'h1
`define SW_STBY         2'h2
`define SWITCH_RESET_VAL 8'h00
// cause register fields
`define CAUSE_TEMP_LSB  0
`define CAUSE_H2P_BIT   4
`define CAUSE_O2P_BIT   5
`define CAUSE_VOL_BIT   6
`define CAUSE_H2D_BIT   7
// debounce time in microseconds and derived cycles at 20 MHz
`define DEBOUNCE_US     10
`define CLK_MHZ         20
`define DEBOUNCE_CYC    (`DEBOUNCE_US * `CLK_MHZ)
`endif

// ==== rtl/safety_panel.v ====
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
`include "panel_map.vh"

// Overview of operation
// - lower temperature switch lights yellow module lamp only, no shutdown
// - upper temperature switch lights red module lamp and shuts system down
// - hydrogen over-pressure lights red lamp and shuts system down
// - oxygen over-pressure lights red lamp and shuts system down
// - either electrolyte limit switch lights red lamp and shuts down
// - cabinet hydrogen detector lights red lamp and turns system off
// - shutdown or mains loss darkens the system reset lamp
// - reset must be pressed before restart; accepted only with no cause present or with override active
// - with reset dark, control lamps follow switch positions
// - reset off keeps pumps, water feed and modules de-energized
// - override active lights yellow and suppresses every automatic shutdown except mains loss
// - module purge open when reset dark; closed when lit unless purge active
// - modules one to three on/off; module four off/standby/on
// - water feed has automatic and off modes; pump running indicator
// - manual mode uses high/low switch; auto uses pressure switch; show mode
// - module four standby runs fixed low current regardless of mode
// - cabinet purge switch energizes solenoid and lights red
// - shutdown removes power, stops pumps, clears reset, opens purge, shows cause
// - every module and pump on-command is gated by the operate signal; the cabinet purge solenoid is not
// - shutdown clears the operate latch; override can block the shutdown
// - shutdown formed continuously from all safety inputs
// - each safety sensor except mains has a cause latch cleared only by the reset button
// - module current from on, high and standby; off gives zero
// - auto mode drops to low at upper pressure point, high at lower point
module safety_panel #(
  parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYC
) (
  input  wire        MCLK,
  input  wire        RST,
  input  wire [3:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  output reg  [31:0] AVS_READDATA,
  output wire        AVS_WAITREQUEST,
  input  wire [3:0]  TEMP_WARN,
  input  wire [3:0]  TEMP_HIGH,
  input  wire        H2_PRESS_HIGH,
  input  wire        O2_PRESS_HIGH,
  input  wire        VOL_HIGH,
  input  wire        VOL_LOW,
  input  wire        H2_DETECT,
  input  wire        MAINS_OK,
  input  wire        O2_PRESS_UPPER,
  input  wire        O2_PRESS_LOWER,
  input  wire        FEED_DEMAND,
  output reg  [3:0]  TEMP_WARN_LAMP,
  output reg  [3:0]  TEMP_HIGH_LAMP,
  output reg         H2_PRESS_LAMP,
  output reg         O2_PRESS_LAMP,
  output reg         VOL_LAMP,
  output reg         H2_DETECT_LAMP,
  output reg         RESET_LAMP,
  output reg         OVERRIDE_LAMP,
  output reg         PURGE_SW_LAMP,
  output reg         MODULE_PURGE_VALVE,
  output reg         CAB_PURGE_VALVE,
  output reg         CAB_PURGE_LAMP,
  output reg         ELYTE_PUMP_ON,
  output reg         FEED_PUMP_ON,
  output reg         FEED_RUN_LAMP,
  output reg         FEED_SW_LAMP,
  output reg  [3:0]  MOD_ON,
  output reg  [3:0]  MOD_HIGH,
  output reg  [3:0]  MOD_STBY,
  output reg  [3:0]  MOD_SW_LAMP,
  output reg         MANUAL_LAMP,
  output reg         AUTO_LAMP,
  output reg         HIGH_MODE_LAMP
);

  localparam CW = 16;

  reg  [7:0]  ctrl_reg;
  reg  [7:0]  switch_reg;
  reg  [7:0]  cause_reg;
  reg  [7:0]  cause_next;
  reg         operate_latch_reg;
  reg         auto_high_reg;
  reg         stby4_reg;
  reg  [15:0] sync1_reg;
  reg  [15:0] sync2_reg;
  reg  [15:0] sync3_reg;
  reg  [15:0] clean_reg;
  reg         rd_ack_reg;
  reg  [31:0] rd_mux;
  wire [2:0]  op_clean;
  reg         h2p;
  reg         o2p;
  reg         volx;
  reg         h2d;
  reg  [3:0]  thi;
  reg  [3:0]  twarn;
  reg         mains;
  reg         pup;
  reg         plow;
  reg         feed_dem;

  wire        wr_en = AVS_WRITE;
  wire        sys_reset_button = op_clean[0];
  wire        shutdown_override_switch = op_clean[1];
  wire        purge_sw = op_clean[2];
  wire [15:0] raw_in = {TEMP_WARN, FEED_DEMAND, O2_PRESS_LOWER, O2_PRESS_UPPER, MAINS_OK, H2_DETECT,
                        VOL_LOW | VOL_HIGH, O2_PRESS_HIGH, H2_PRESS_HIGH, TEMP_HIGH};
  wire [7:0]  cause_now;
  wire        safety_trip;
  wire        mains_lost;
  wire        shutdown;
  wire        operate;
  wire        manual;
  wire        want_high;
  wire [3:0]  sw_on;

  // reads take one wait state so that read data comes from a flop
  assign AVS_WAITREQUEST = AVS_READ & ~rd_ack_reg;

  function [1:0] mod_sel;
    input [7:0] sw;
    input integer idx;
    begin
      mod_sel = sw[idx*2 +: 2];
    end
  endfunction

  // three-flop sync on every pin
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sync1_reg <= 16'h0000;
      sync2_reg <= 16'h0000;
      sync3_reg <= 16'h0000;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // a change counts when second and third agree; mains rests high to match its idle pin
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      clean_reg <= 16'h0100;
    end else begin
      clean_reg <= (sync2_reg & sync3_reg) | (clean_reg & (sync2_reg | sync3_reg));
    end
  end

  always @* begin
    thi      = clean_reg[3:0];
    h2p      = clean_reg[4];
    o2p      = clean_reg[5];
    volx     = clean_reg[6];
    h2d      = clean_reg[7];
    mains    = clean_reg[8];
    pup      = clean_reg[9];
    plow     = clean_reg[10];
    feed_dem = clean_reg[11];
    twarn    = clean_reg[15:12];
  end

  // debounce of the reset, override and purge controls held in ctrl_reg bits 0 to 2
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : deb
      reg          q_reg;
      reg          clean_bit_reg;
      reg [CW-1:0] cnt_reg;
      wire         raw_bit = ctrl_reg[g];
      assign op_clean[g] = clean_bit_reg;
      // a level must hold for the whole count; any bounce restarts it
      always @(posedge MCLK or posedge RST) begin
        if (RST) begin
          cnt_reg       <= {CW{1'b0}};
          q_reg         <= 1'b0;
          clean_bit_reg <= 1'b0;
        end else begin
          q_reg <= raw_bit;
          if (q_reg == clean_bit_reg) begin
            cnt_reg <= {CW{1'b0}};
          end else if (cnt_reg >= DEBOUNCE_CYCLES[CW-1:0] - 16'h0001) begin
            clean_bit_reg <= q_reg;
            cnt_reg       <= {CW{1'b0}};
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
      end
    end
  endgenerate

  assign cause_now   = {h2d, volx, o2p, h2p, thi};
  assign safety_trip = (|cause_now) & ~shutdown_override_switch;
  // mains loss has no latch and no override: the plant must be restarted by hand
  assign mains_lost  = ~mains;
  assign shutdown    = safety_trip | mains_lost;

  // cause latches: set wins over the reset button
  always @* begin
    cause_next = cause_reg | cause_now;
    if (sys_reset_button) begin
      cause_next = cause_now;
    end
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cause_reg <= 8'h00;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // operate latch: shutdown forces rest, reset with no cause arms it
  // shutdown is tested first, so a fault during the press still wins
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      operate_latch_reg <= 1'b0;
    end else begin
      if (shutdown) begin
        operate_latch_reg <= 1'b0;
      end else if (sys_reset_button && ((cause_now == 8'h00) || shutdown_override_switch)) begin
        operate_latch_reg <= 1'b1;
      end
    end
  end

  assign operate   = operate_latch_reg;
  assign manual    = ctrl_reg[`CTRL_MANUAL_BIT];
  assign want_high = manual ? ctrl_reg[`CTRL_HIGH_BIT] : auto_high_reg;

  // automatic current hysteresis on the discharge pressure switch
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      auto_high_reg <= 1'b1;
    end else if (pup) begin
      auto_high_reg <= 1'b0;
    end else if (plow) begin
      auto_high_reg <= 1'b1;
    end
  end

  generate
    for (g = 0; g < 4; g = g + 1) begin : msw
      assign sw_on[g] = (mod_sel(switch_reg, g) == `SW_ON) ||
                        ((g == 3) && (mod_sel(switch_reg, g) == `SW_STBY));
    end
  endgenerate

  // cause lamps follow the latches, so the first fault stays on show after it clears
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      TEMP_WARN_LAMP <= 4'h0;
      TEMP_HIGH_LAMP <= 4'h0;
      H2_PRESS_LAMP  <= 1'b0;
      O2_PRESS_LAMP  <= 1'b0;
      VOL_LAMP       <= 1'b0;
      H2_DETECT_LAMP <= 1'b0;
    end else begin
      TEMP_WARN_LAMP <= twarn;
      TEMP_HIGH_LAMP <= cause_reg[3:0];
      H2_PRESS_LAMP  <= cause_reg[`CAUSE_H2P_BIT];
      O2_PRESS_LAMP  <= cause_reg[`CAUSE_O2P_BIT];
      VOL_LAMP       <= cause_reg[`CAUSE_VOL_BIT];
      H2_DETECT_LAMP <= cause_reg[`CAUSE_H2D_BIT];
    end
  end

  // safety controls; module purge rests open so a dead latch fails safe
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      RESET_LAMP         <= 1'b0;
      OVERRIDE_LAMP      <= 1'b0;
      PURGE_SW_LAMP      <= 1'b0;
      MODULE_PURGE_VALVE <= 1'b1;
      CAB_PURGE_VALVE    <= 1'b0;
      CAB_PURGE_LAMP     <= 1'b0;
    end else begin
      RESET_LAMP         <= operate;
      OVERRIDE_LAMP      <= shutdown_override_switch;
      PURGE_SW_LAMP      <= purge_sw;
      MODULE_PURGE_VALVE <= ~operate | purge_sw;
      CAB_PURGE_VALVE    <= ctrl_reg[`CTRL_CABP_BIT];
      CAB_PURGE_LAMP     <= ctrl_reg[`CTRL_CABP_BIT];
    end
  end

  // pumps; the run lamp uses the same term as the pump so it never lags it
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ELYTE_PUMP_ON <= 1'b0;
      FEED_PUMP_ON  <= 1'b0;
      FEED_RUN_LAMP <= 1'b0;
      FEED_SW_LAMP  <= 1'b0;
    end else begin
      ELYTE_PUMP_ON <= operate & ctrl_reg[`CTRL_RESET_BIT + 7];
      FEED_PUMP_ON  <= operate & ctrl_reg[`CTRL_FEED_BIT] & feed_dem;
      FEED_RUN_LAMP <= operate & ctrl_reg[`CTRL_FEED_BIT] & feed_dem;
      FEED_SW_LAMP  <= ctrl_reg[`CTRL_FEED_BIT];
    end
  end

  // module current controls and current mode lamps
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      stby4_reg      <= 1'b0;
      MOD_ON         <= 4'h0;
      MOD_HIGH       <= 4'h0;
      MOD_STBY       <= 4'h0;
      MOD_SW_LAMP    <= 4'h0;
      MANUAL_LAMP    <= 1'b0;
      AUTO_LAMP      <= 1'b0;
      HIGH_MODE_LAMP <= 1'b0;
    end else begin
      stby4_reg       <= (mod_sel(switch_reg, 3) == `SW_STBY);
      MOD_ON          <= {4{operate}} & sw_on;
      MOD_HIGH        <= {4{operate & want_high}} & sw_on & {~stby4_reg, 3'h7};
      MOD_STBY        <= {operate & stby4_reg, 3'h0};
      MOD_SW_LAMP     <= operate ? ({4{operate}} & sw_on) : sw_on;
      MANUAL_LAMP     <= manual;
      AUTO_LAMP       <= ~manual;
      HIGH_MODE_LAMP  <= want_high;
    end
  end

  // avalon slave, writes take zero wait states and land on the edge
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl_reg   <= `CTRL_RESET_VAL;
      switch_reg <= `SWITCH_RESET_VAL;
    end else if (wr_en) begin
      case (AVS_ADDRESS)
        `REG_CTRL:   ctrl_reg   <= AVS_WRITEDATA[7:0];
        `REG_SWITCH: switch_reg <= AVS_WRITEDATA[7:0];
        default:     ctrl_reg   <= ctrl_reg;
      endcase
    end
  end

  // unmapped offsets read as zero
  always @* begin
    case (AVS_ADDRESS)
      `REG_CTRL:   rd_mux = {24'h000000, ctrl_reg};
      `REG_SWITCH: rd_mux = {24'h000000, switch_reg};
      `REG_CAUSE:  rd_mux = {24'h000000, cause_reg};
      `REG_STATUS: rd_mux = {24'h000000, mains, auto_high_reg, shutdown, operate,
                             op_clean, 1'b0};
      default:     rd_mux = 32'h00000000;
    endcase
  end

  // read data is registered; the ack flop drops waitrequest one edge later
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rd_ack_reg   <= 1'b0;
      AVS_READDATA <= 32'h00000000;
    end else begin
      rd_ack_reg   <= AVS_READ & ~rd_ack_reg;
      AVS_READDATA <= rd_mux;
    end
  end

endmodule // safety_panel

// ==== verif/panel_properties.sv ====
`timescale 1ns/1ns
module panel_chk (
  input wire       MCLK,
  input wire       RST,
  input wire       AVS_READ,
  input wire       AVS_WRITE,
  input wire       AVS_WAITREQUEST,
  input wire [3:0] TEMP_WARN,
  input wire [3:0] TEMP_HIGH,
  input wire       H2_PRESS_HIGH,
  input wire       MAINS_OK,
  input wire [3:0] TEMP_WARN_LAMP,
  input wire       H2_PRESS_LAMP,
  input wire       RESET_LAMP,
  input wire       OVERRIDE_LAMP,
  input wire       MODULE_PURGE_VALVE,
  input wire       CAB_PURGE_VALVE,
  input wire       CAB_PURGE_LAMP,
  input wire       ELYTE_PUMP_ON,
  input wire       FEED_PUMP_ON,
  input wire       FEED_RUN_LAMP,
  input wire [3:0] MOD_ON,
  input wire [3:0] MOD_HIGH,
  input wire [3:0] MOD_STBY,
  input wire       MANUAL_LAMP,
  input wire       AUTO_LAMP
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // outputs are registered, so gates get two cycles of slack after the lamp goes dark
  sequence dark3; !RESET_LAMP [*3]; endsequence
  sequence h2_held; H2_PRESS_HIGH [*8]; endsequence
  sequence mains_lost; !MAINS_OK [*8] ##0 !OVERRIDE_LAMP; endsequence
  write_nowait_a: assert property (AVS_WRITE |-> !AVS_WAITREQUEST) else $error("write waited");
  read_wait_a: assert property (AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("read hung");
  dark_gate_a: assert property (dark3 |-> MOD_ON == 4'h0 && !ELYTE_PUMP_ON && !FEED_PUMP_ON)
    else $error("drive while dark");
  dark_purge_a: assert property (dark3 |-> MODULE_PURGE_VALVE) else $error("purge shut");
  temp_trip_a: assert property ($rose(TEMP_HIGH[0]) && !OVERRIDE_LAMP |-> ##[1:8] !RESET_LAMP)
    else $error("no temp trip");
  h2_lamp_a: assert property (h2_held |-> H2_PRESS_LAMP) else $error("no h2 lamp");
  mains_drop_a: assert property (mains_lost |-> !RESET_LAMP) else $error("lit on mains loss");
  warn_lamp_a: assert property ($stable(TEMP_WARN) [*6] |-> TEMP_WARN_LAMP == TEMP_WARN)
    else $error("warn lamp");
  cab_purge_a: assert property (CAB_PURGE_LAMP == CAB_PURGE_VALVE) else $error("cab lamp");
  feed_lamp_a: assert property (FEED_RUN_LAMP == FEED_PUMP_ON) else $error("feed lamp");
  stby_low_a: assert property (MOD_STBY != 4'h0 |-> MOD_STBY == 4'h8 && !MOD_HIGH[3])
    else $error("standby");
  mode_lamp_a: assert property (!(MANUAL_LAMP && AUTO_LAMP)) else $error("both modes");
endmodule // panel_chk
bind safety_panel panel_chk u_chk (.*);

// ==== verif/plant_model.sv ====
`timescale 1ns/1ns
module plant_model (
  input  wire       clk,
  input  wire [9:0] fault,
  input  wire [3:0] mod_on,
  output wire [3:0] temp_high,
  output wire       h2_high,
  output wire       o2_high,
  output wire       vol_high,
  output wire       vol_low,
  output wire       h2_det,
  output wire       mains_ok,
  output wire       o2_upper,
  output wire       o2_lower,
  output wire       feed_demand
);
  reg [9:0] f_reg = 10'h000;
  reg [5:0] p_reg = 6'h18;
  // pressure climbs while any module runs, so the switch points really move
  always @(posedge clk) begin
    f_reg <= fault;
    if (|mod_on && p_reg < 6'h1E)
      p_reg <= p_reg + 6'h01;
    else if (!(|mod_on) && p_reg > 6'h10)
      p_reg <= p_reg - 6'h01;
  end
  assign {h2_det, vol_low, vol_high, o2_high, h2_high, temp_high} = f_reg[8:0];
  assign mains_ok = !f_reg[9];
  assign o2_upper = p_reg >= 6'h1B;
  assign o2_lower = p_reg <= 6'h15;
  assign feed_demand = p_reg[2];
endmodule // plant_model

// ==== verif/test_safety_panel.sv ====
`timescale 1ns/1ns
module test_safety_panel;
  localparam DB = 4;
  reg         MCLK = 1'b0, RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  reg  [3:0]  AVS_ADDRESS = 4'h0, TEMP_WARN = 4'h0;
  reg  [31:0] AVS_WRITEDATA = 32'h0, rd, ctrl;
  reg  [9:0]  fault = 10'h000;
  wire [3:0]  TEMP_HIGH, TEMP_WARN_LAMP, TEMP_HIGH_LAMP, MOD_ON, MOD_HIGH, MOD_STBY, MOD_SW_LAMP;
  wire [31:0] AVS_READDATA;
  wire        AVS_WAITREQUEST, H2_PRESS_HIGH, O2_PRESS_HIGH, VOL_HIGH, VOL_LOW, H2_DETECT, MAINS_OK;
  wire        O2_PRESS_UPPER, O2_PRESS_LOWER, FEED_DEMAND, H2_PRESS_LAMP, O2_PRESS_LAMP, VOL_LAMP;
  wire        H2_DETECT_LAMP, RESET_LAMP, OVERRIDE_LAMP, PURGE_SW_LAMP, MODULE_PURGE_VALVE, CAB_PURGE_VALVE;
  wire        CAB_PURGE_LAMP, ELYTE_PUMP_ON, FEED_PUMP_ON, FEED_RUN_LAMP, FEED_SW_LAMP, MANUAL_LAMP;
  wire        AUTO_LAMP, HIGH_MODE_LAMP;
  integer     mismatches = 0, checked = 0, cyc = 0, i, seed = 32'hA7C9;
  reg  [31:0] q_exp[$];
  integer     q_kind[$];
  event       look;
  always #25 MCLK = !MCLK;
  safety_panel #(.DEBOUNCE_CYCLES(DB)) u_dut (.*);
  plant_model u_plant (.clk(MCLK), .fault(fault), .mod_on(MOD_ON), .temp_high(TEMP_HIGH),
    .h2_high(H2_PRESS_HIGH), .o2_high(O2_PRESS_HIGH), .vol_high(VOL_HIGH), .vol_low(VOL_LOW),
    .h2_det(H2_DETECT), .mains_ok(MAINS_OK), .o2_upper(O2_PRESS_UPPER), .o2_lower(O2_PRESS_LOWER),
    .feed_demand(FEED_DEMAND));
  function [31:0] view(input integer k);
    case (k)
      0: view = {22'h0, RESET_LAMP, MODULE_PURGE_VALVE, H2_DETECT_LAMP, VOL_LAMP, O2_PRESS_LAMP,
                 H2_PRESS_LAMP, TEMP_HIGH_LAMP};
      1: view = rd;
      2: view = {22'h0, MOD_SW_LAMP, MOD_ON, ELYTE_PUMP_ON, FEED_PUMP_ON};
      default: view = {21'h0, CAB_PURGE_VALVE, MANUAL_LAMP, HIGH_MODE_LAMP, MOD_HIGH, MOD_STBY};
    endcase
  endfunction
  function [31:0] cause(input integer f);
    cause = f < 6 ? 32'h1 << f : f < 8 ? 32'h40 : f == 8 ? 32'h80 : 32'h0;
  endfunction
  task stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task cmp(input integer k, input [31:0] e, input [31:0] s);
    checked = checked + 1;
    if (s !== e) begin
      mismatches = mismatches + 1;
      $display("Error view%0d expected %h seen %h", k, e, s);
    end
  endtask
  // the watcher samples on a falling edge, away from every register update
  always @(look) begin : watch
    integer k;
    k = q_kind.pop_front();
    cmp(k, q_exp.pop_front(), view(k));
  end
  task note(input integer k, input [31:0] e);
    @(negedge MCLK);
    q_exp.push_back(e);
    q_kind.push_back(k);
    ->look;
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    integer n;
    n = 0;
    @(posedge MCLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do begin
      @(posedge MCLK);
      n = n + 1;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    if (n >= 50)
      mismatches = mismatches + 1;
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  // held past the debounce time, or the press would be filtered out as bounce
  task press(input [31:0] b);
    bus(1'b1, 4'h0, ctrl | b);
    repeat (DB + 8) @(posedge MCLK);
    bus(1'b1, 4'h0, ctrl);
    repeat (DB + 8) @(posedge MCLK);
  endtask
  task wait_lamp(input v);
    integer n;
    for (n = 0; n < 40 && RESET_LAMP !== v; n = n + 1) @(posedge MCLK);
    repeat (2) @(posedge MCLK);
  endtask
  always @(posedge MCLK) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      stop_test;
    end
  end
  initial begin
    repeat (6) @(posedge MCLK);
    RST <= 1'b0;
    note(0, 32'h100);
    note(2, 32'h0);
    bus(1'b1, 4'h4, 32'h95);
    ctrl = 32'hF0;
    bus(1'b1, 4'h0, ctrl);
    press(32'h1);
    wait_lamp(1'b1);
    note(0, 32'h200);
    note(3, 32'h378);
    ctrl = 32'hD0;
    bus(1'b1, 4'h0, ctrl);
    repeat (DB + 8) @(posedge MCLK);
    note(3, 32'h208);
    bus(1'b0, 4'h0, 32'h0);
    note(1, 32'hD0);
    bus(1'b0, 4'h1, 32'h0);
    note(1, 32'h0);
    $display("setup test done");
    for (i = 0; i < 10; i = i + 1) begin
      @(posedge MCLK);
      fault <= 10'h001 << i;
      wait_lamp(1'b0);
      note(0, 32'h100 | cause(i));
      note(2, 32'h3C0);
      press(32'h1);
      note(0, 32'h100 | cause(i));
      @(posedge MCLK);
      fault <= 10'h000;
      press(32'h1);
      wait_lamp(1'b1);
      note(0, 32'h200);
    end
    $display("fault test done");
    @(posedge MCLK);
    TEMP_WARN <= $random(seed) | 4'h1;
    repeat (10) @(posedge MCLK);
    note(0, 32'h200);
    TEMP_WARN <= 4'h0;
    ctrl = 32'hDE;
    bus(1'b1, 4'h0, ctrl);
    repeat (DB + 8) @(posedge MCLK);
    note(3, 32'h608);
    fault <= 10'h100;
    repeat (16) @(posedge MCLK);
    note(0, 32'h380);
    fault <= 10'h000;
    ctrl = 32'hD0;
    press(32'h1);
    wait_lamp(1'b1);
    note(0, 32'h200);
    $display("override test done");
    stop_test;
  end
endmodule // test_safety_panel
